// ---- bench/gnmsr_regs_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module gnmsr_regs_monitor
  import gnmsr_pkg::*;
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire gnmsr_status_t status_in,
  input wire gnmsr_ctrl_t   ctrl_out,
  input wire logic          idle_overflow
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  AST_ONE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_HI: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper data set");
  AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error data set");
  AST_MAN: assert property (ctrl_out.role_master |-> ctrl_out.role_manual)
    else $error("role without manual");
  AST_PORT: assert property (ctrl_out.port_multi |-> !ctrl_out.role_manual)
    else $error("port with manual");
  AST_TEST: assert property (ctrl_out.test_mode <= GNMSR_TM_DISTORTION)
    else $error("reserved mode out");
  AST_SAT: assert property (idle_overflow |=> !idle_overflow)
    else $error("overflow repeats");
  AST_OVF: assert property (idle_overflow |-> $past(status_in.idle_error))
    else $error("overflow without error");
endmodule // gnmsr_regs_monitor
bind gnmsr_regs gnmsr_regs_monitor mon (.*);
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench import gnmsr_pkg::*;;
  logic          pclk, presetn, psel, penable, pwrite, soft_reset, np_rx_valid;
  logic          pready, pslverr, idle_overflow, ev;
  logic [31:0]   paddr, pwdata, prdata, rv;
  logic [3:0]    pstrb;
  logic [15:0]   np_rx_word;
  gnmsr_strap_t  strap;
  gnmsr_status_t status_in;
  gnmsr_ctrl_t   ctrl_out;
  int            n_fail, checks_done, cyc, novf;
  logic [31:0]   ra[6] = '{32'h20, 32'h24, 32'h28, 32'h18, 32'h24, 32'h20};
  logic [31:0]   rd_[6] = '{0, 0, 0, 0, 32'hFFFFFFFF, 32'hFFFF};
  logic [31:0]   re[6] = '{32'h2000, 32'h1600, 0, 0, 32'hFF00, 32'h2000};
  gnmsr_regs dut (.*);
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    novf <= novf + int'(idle_overflow === 1'b1);
    if (cyc == 3000) report_and_stop(1);
  end
  task automatic report_and_stop(input int extra);
    n_fail += extra;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input string nm, input logic [31:0] a, e);
    bus(1'b0, a, 0);
    chk(nm, e, rv);
  endtask
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, soft_reset, np_rx_valid} = '0;
    {paddr, pwdata, np_rx_word, status_in} = '0;
    pstrb = 4'hF;
    strap = 5'b10110;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("strap", 32'h12, ctrl_out);
    for (int i = 0; i < 6; i++)
    begin
      if (i > 3) bus(1'b1, ra[i], rd_[i]);
      rd("row", ra[i], re[i]);
    end
    chk("ctrl", 32'h1B, ctrl_out);
    $display("rows done");
    for (int t = 0; t < 8; t++)
    begin
      bus(1'b1, 32'h24, {16'h0, t[2:0], 13'h0C00});
      @(posedge pclk);
      chk("mode", {(t < 5) ? t[2:0] : 3'h0, 5'h04}, ctrl_out);
    end
    bus(1'b0, 32'h2C, 0);
    chk("unmapped", 32'h1, {31'h0, ev});
    chk("unmapped data", 32'h0, rv);
    bus(1'b0, 32'h21, 0);
    chk("misaligned", 32'h1, {31'h0, ev});
    pstrb <= 4'hD;
    bus(1'b1, 32'h24, 0);
    pstrb <= 4'hF;
    rd("strobe", 32'h24, 32'hEC00);
    $display("modes done");
    status_in <= 8'hFD;
    @(posedge pclk);
    status_in <= 8'h7C;
    rd("stat", 32'h28, 32'hFC00);
    rd("stat", 32'h28, 32'h7C00);
    rd("exp", 32'h18, 32'h2);
    rd("exp", 32'h18, 32'h0);
    status_in <= 8'h02;
    repeat (3) @(posedge pclk);
    status_in <= 8'h00;
    rd("idle", 32'h28, 32'h3);
    rd("idle", 32'h28, 32'h0);
    status_in <= 8'h02;
    repeat (300) @(posedge pclk);
    status_in <= 8'h00;
    rd("idle", 32'h28, 32'hFF);
    chk("ovf", 32'h1, novf);
    status_in <= 8'h02;
    @(posedge pclk);
    status_in <= 8'h00;
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    rd("idle soft", 32'h28, 32'h0);
    $display("status done");
    np_rx_word <= 16'hFFFF;
    for (int k = 0; k < 2; k++)
    begin
      np_rx_valid <= 1'b1;
      @(posedge pclk);
      np_rx_valid <= 1'b0;
      rd("np", 32'h20, k ? 32'hF7FF : 32'hFFFF);
    end
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("np", 32'h20, 32'h2000);
    $display("np done");
    report_and_stop(0);
  end
endmodule // testbench
`default_nettype wire

// ---- logic/gnmsr_pkg.sv ----
package gnmsr_pkg;

  localparam logic [3:0] GNMSR_IDX_EXPANSION = 4'h6;
  localparam logic [3:0] GNMSR_IDX_NP_RX     = 4'h8;
  localparam logic [3:0] GNMSR_IDX_CTRL      = 4'h9;
  localparam logic [3:0] GNMSR_IDX_STAT      = 4'hA;
  localparam int         GNMSR_ADDR_LSB      = 2;
  localparam int         GNMSR_IDX_W         = 4;

  localparam int GNMSR_NP_NEXT   = 15;
  localparam int GNMSR_NP_ACK    = 14;
  localparam int GNMSR_NP_MSG    = 13;
  localparam int GNMSR_NP_ACK2   = 12;
  localparam int GNMSR_NP_TOGGLE = 11;
  localparam logic [15:0] GNMSR_NP_RESET = 16'h2000;

  localparam int GNMSR_CT_TEST_HI = 15;
  localparam int GNMSR_CT_TEST_LO = 13;
  localparam int GNMSR_CT_MAN_EN  = 12;
  localparam int GNMSR_CT_MAN_VAL = 11;
  localparam int GNMSR_CT_PORT    = 10;
  localparam int GNMSR_CT_ADV_FD  = 9;
  localparam int GNMSR_CT_ADV_HD  = 8;

  localparam int GNMSR_ST_FAULT   = 15;
  localparam int GNMSR_ST_MASTER  = 14;
  localparam int GNMSR_ST_LOC_OK  = 13;
  localparam int GNMSR_ST_REM_OK  = 12;
  localparam int GNMSR_ST_LP_FD   = 11;
  localparam int GNMSR_ST_LP_HD   = 10;
  localparam int GNMSR_EX_PAGE_RX = 1;

  localparam logic [7:0]  GNMSR_IDLE_MAX = 8'hFF;
  localparam logic [7:0]  GNMSR_IDLE_ONE = 8'h01;
  localparam logic [2:0]  GNMSR_TEST_RESET = 3'h0;

  typedef enum logic [2:0] {
    GNMSR_TM_NORMAL     = 3'h0,
    GNMSR_TM_WAVEFORM   = 3'h1,
    GNMSR_TM_JIT_MASTER = 3'h2,
    GNMSR_TM_JIT_SLAVE  = 3'h3,
    GNMSR_TM_DISTORTION = 3'h4
  } gnmsr_test_t;

  typedef struct packed {
    logic man_en;
    logic man_val;
    logic port_multi;
    logic adv_full;
    logic adv_half;
  } gnmsr_strap_t;

  typedef struct packed {
    logic ms_fault;
    logic resolved_master;
    logic local_rx_ok;
    logic remote_rx_ok;
    logic partner_gig_full_ability;
    logic partner_gig_half_ability;
    logic idle_error;
    logic page_received;
  } gnmsr_status_t;

  typedef struct packed {
    gnmsr_test_t test_mode;
    logic        role_manual;
    logic        role_master;
    logic        port_multi;
    logic        adv_full;
    logic        adv_half;
  } gnmsr_ctrl_t;

  typedef struct packed {
    logic         strap_done;
    logic [15:0]  np_word;
    logic [2:0]   test_field;
    gnmsr_strap_t ctrl;
    logic         fault;
    logic         page_rx;
    logic [7:0]   idle_cnt;
    logic         idle_ovf;
    gnmsr_ctrl_t  ctrl_out;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } gnmsr_state_t;

endpackage

// ---- logic/gnmsr_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
module gnmsr_regs
  import gnmsr_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output var  logic [31:0]   prdata,
  output var  logic          pready,
  output var  logic          pslverr,
  input  wire gnmsr_strap_t  strap,
  input  wire logic          soft_reset,
  input  wire logic          np_rx_valid,
  input  wire logic [15:0]   np_rx_word,
  input  wire gnmsr_status_t status_in,
  output var  gnmsr_ctrl_t   ctrl_out,
  output var  logic          idle_overflow
);

  gnmsr_state_t s_q;
  gnmsr_state_t s_d;
  logic [GNMSR_IDX_W-1:0] idx;
  logic                   hit;
  logic                   done;
  logic                   rd_take;
  logic                   wr_ctrl;
  logic [15:0]            rd_word;

  always_comb
  begin
    idx     = paddr[GNMSR_ADDR_LSB +: GNMSR_IDX_W];
    hit     = (paddr[GNMSR_ADDR_LSB-1:0] == 2'h0)
              && (paddr[31:GNMSR_ADDR_LSB+GNMSR_IDX_W] == '0)
              && (idx == GNMSR_IDX_EXPANSION || idx == GNMSR_IDX_NP_RX
                  || idx == GNMSR_IDX_CTRL || idx == GNMSR_IDX_STAT);
    done    = psel && penable && s_q.pready;
    rd_take = psel && penable && !s_q.pready && !pwrite && hit;
    wr_ctrl = done && pwrite && hit && idx == GNMSR_IDX_CTRL && pstrb[1];
    rd_word = '0;
    unique case (idx)
      GNMSR_IDX_EXPANSION:
      begin
        rd_word[GNMSR_EX_PAGE_RX] = s_q.page_rx;
      end
      GNMSR_IDX_NP_RX:
      begin
        rd_word = s_q.np_word;
      end
      GNMSR_IDX_CTRL:
      begin
        rd_word[GNMSR_CT_TEST_HI:GNMSR_CT_TEST_LO] = s_q.test_field;
        rd_word[GNMSR_CT_MAN_EN]  = s_q.ctrl.man_en;
        rd_word[GNMSR_CT_MAN_VAL] = s_q.ctrl.man_val;
        rd_word[GNMSR_CT_PORT]    = s_q.ctrl.port_multi;
        rd_word[GNMSR_CT_ADV_FD]  = s_q.ctrl.adv_full;
        rd_word[GNMSR_CT_ADV_HD]  = s_q.ctrl.adv_half;
      end
      GNMSR_IDX_STAT:
      begin
        rd_word[GNMSR_ST_FAULT]  = s_q.fault;
        rd_word[GNMSR_ST_MASTER] = status_in.resolved_master;
        rd_word[GNMSR_ST_LOC_OK] = status_in.local_rx_ok;
        rd_word[GNMSR_ST_REM_OK] = status_in.remote_rx_ok;
        rd_word[GNMSR_ST_LP_FD]  = status_in.partner_gig_full_ability;
        rd_word[GNMSR_ST_LP_HD]  = status_in.partner_gig_half_ability;
        rd_word[$bits(s_q.idle_cnt)-1:0] = s_q.idle_cnt;
      end
      default:
      begin
        rd_word = '0;
      end
    endcase
  end

  always_comb
  begin
    s_d = s_q;

    // The bus answers after one wait state; unmapped addresses flag an error.
    s_d.pready  = psel && penable && !s_q.pready;
    s_d.pslverr = psel && penable && !s_q.pready && !hit;
    if (psel && penable && !s_q.pready)
    begin
      s_d.prdata = (pwrite || !hit) ? '0 : {16'h0000, rd_word};
    end

    // Straps are captured on the first edge after reset is released.
    if (!s_q.strap_done)
    begin
      s_d.strap_done = 1'b1;
      s_d.ctrl       = strap;
    end

    // Only the control fields take writes; reserved bits are dropped.
    if (wr_ctrl)
    begin
      s_d.test_field      = pwdata[GNMSR_CT_TEST_HI:GNMSR_CT_TEST_LO];
      s_d.ctrl.man_en     = pwdata[GNMSR_CT_MAN_EN];
      s_d.ctrl.man_val    = pwdata[GNMSR_CT_MAN_VAL];
      s_d.ctrl.port_multi = pwdata[GNMSR_CT_PORT];
      s_d.ctrl.adv_full   = pwdata[GNMSR_CT_ADV_FD];
      s_d.ctrl.adv_half   = pwdata[GNMSR_CT_ADV_HD];
    end

    // A new partner page is stored; toggle inverts the stored toggle.
    if (np_rx_valid)
    begin
      s_d.np_word = np_rx_word;
      s_d.np_word[GNMSR_NP_TOGGLE] = !s_q.np_word[GNMSR_NP_TOGGLE];
    end

    // Latched bits clear as the read data is taken, but a present event wins.
    if (rd_take && idx == GNMSR_IDX_STAT)
    begin
      s_d.fault = 1'b0;
    end
    if (status_in.ms_fault)
    begin
      s_d.fault = 1'b1;
    end
    if (rd_take && idx == GNMSR_IDX_EXPANSION)
    begin
      s_d.page_rx = 1'b0;
    end
    if (status_in.page_received)
    begin
      s_d.page_rx = 1'b1;
    end

    // Idle error counter: clears on read or soft reset, saturates.
    s_d.idle_ovf = 1'b0;
    if (soft_reset || (rd_take && idx == GNMSR_IDX_STAT))
    begin
      s_d.idle_cnt = status_in.idle_error ? GNMSR_IDLE_ONE : '0;
    end
    else if (status_in.idle_error && s_q.idle_cnt != GNMSR_IDLE_MAX)
    begin
      s_d.idle_cnt = s_q.idle_cnt + GNMSR_IDLE_ONE;
      s_d.idle_ovf = (s_q.idle_cnt == GNMSR_IDLE_MAX - GNMSR_IDLE_ONE);
    end
    if (soft_reset)
    begin
      s_d.idle_ovf = 1'b0;
    end

    // Control outputs decode the registered fields.
    unique case (s_q.test_field)
      GNMSR_TM_WAVEFORM, GNMSR_TM_JIT_MASTER, GNMSR_TM_JIT_SLAVE, GNMSR_TM_DISTORTION:
      begin
        s_d.ctrl_out.test_mode = gnmsr_test_t'(s_q.test_field);
      end
      default:
      begin
        s_d.ctrl_out.test_mode = GNMSR_TM_NORMAL;
      end
    endcase
    s_d.ctrl_out.role_manual = s_q.ctrl.man_en;
    s_d.ctrl_out.role_master = s_q.ctrl.man_en && s_q.ctrl.man_val;
    s_d.ctrl_out.port_multi  = !s_q.ctrl.man_en && s_q.ctrl.port_multi;
    s_d.ctrl_out.adv_full    = s_q.ctrl.adv_full;
    s_d.ctrl_out.adv_half    = s_q.ctrl.adv_half;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q            <= '0;
      s_q.np_word    <= GNMSR_NP_RESET;
      s_q.test_field <= GNMSR_TEST_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_comb
  begin
    prdata        = s_q.prdata;
    pready        = s_q.pready;
    pslverr       = s_q.pslverr;
    ctrl_out      = s_q.ctrl_out;
    idle_overflow = s_q.idle_ovf;
  end

endmodule // gnmsr_regs
`default_nettype wire
